// ---- hw/window_watchdog_limp_home.sv ----
// Window watchdog with reset pulse and limp-home failure output
// Summary of operation
// - Power-up holds reset low about 4 ms, then waits for triggers.
// - Limp home stays off at power-up and after sleep wake-up.
// - Watchdog reset turns limp home on; three good triggers turn it off.
// - Trigger during lead time starts the closed window at once.
// - No trigger in lead time gives 4 ms reset and limp home on.
// - Closed window lasts 527 periods, open window 553 periods.
// - Trigger is a falling edge low longer than 200 ns; shorter ignored.
// - Trigger in open window starts a new closed window.
// - Open window expiring without trigger gives reset and limp home.
// - Trigger in closed window is premature: reset and limp home.
// - Trigger period set through oscillator period by timing resistor.
// - Faulty resistor pin falls back to internal oscillator.
// - Control input low enables the watchdog, high disables it.
// - Watchdog runs only in normal and fail-safe modes.
// - Lead time starts at TXD fall after silent, reset rise after sleep.
// - Silent keeps limp home; disabled, sleep or unpowered turn it off.
`timescale 1ns/1ps
module window_watchdog_limp_home #(
   parameter int RESET_CYCLES = wd_pkg::NRES_CYCLES,
   parameter int OSC_FALLBACK = wd_pkg::OSC_FALLBACK_CYCLES
) (
   input wire logic clk_sys,
   input wire logic rst_n,
   input wire logic wd_trigger_in_n,
   input wire logic wd_disable_in,
   input wire logic txd_in,
   input wire logic nres_in,
   input wire wd_pkg::op_mode_t op_mode,
   input wire logic [wd_pkg::OSC_CNT_W-1:0] osc_period_cfg,
   input wire logic osc_resistor_fault,
   output wd_pkg::od_pin_t nres_pin,
   output logic limp_home_out
);
   localparam int LEAD_END = wd_pkg::LEAD_TICKS - 1;
   localparam int CLOSED_END = wd_pkg::CLOSED_TICKS - 1;
   localparam int OPEN_END = wd_pkg::OPEN_TICKS - 1;
   localparam int RESET_END = RESET_CYCLES - 1;

   wd_pkg::wd_regs_t q;
   wd_pkg::wd_regs_t d;
   logic tick;
   logic trig_evt;
   logic txd_fall;
   logic wd_run;
   logic [1:0] good_next;

   osc_timebase #(
      .FALLBACK(OSC_FALLBACK)
   ) u_osc (
      .clk_sys(clk_sys),
      .rst_n(rst_n),
      .osc_period_cfg(osc_period_cfg),
      .osc_resistor_fault(osc_resistor_fault),
      .tick(tick)
   );

   always_comb begin
      d = q;
      // Pins cross into the clock domain through two flops
      d.trig_s1 = wd_trigger_in_n;
      d.trig_s2 = q.trig_s1;
      d.txd_s1 = txd_in;
      d.txd_s2 = q.txd_s1;
      d.dis_s1 = wd_disable_in;
      d.dis_s2 = q.dis_s1;
      d.nres_s1 = nres_in;
      d.nres_s2 = q.nres_s1;
      d.txd_prev = q.txd_s2;
      d.nres.o = 1'b0;
      txd_fall = q.txd_prev & ~q.txd_s2;
      good_next = q.good + 2'h1;
      // Low must outlast the glitch limit; one event per low phase
      trig_evt = 1'b0;
      if (q.trig_s2) begin
         d.low_cnt = '0;
         d.armed = 1'b1;
      end else if (q.low_cnt != wd_pkg::LOW_CNT_W'(wd_pkg::TRIGMIN_CYCLES)) begin
         d.low_cnt = q.low_cnt + 6'h01;
      end else if (q.armed) begin
         trig_evt = 1'b1;
         d.armed = 1'b0;
      end
      wd_run = ~q.dis_s2 && (op_mode == wd_pkg::MODE_NORMAL
         || op_mode == wd_pkg::MODE_FAILSAFE);
      if (q.dis_s2) begin
         d.st = wd_pkg::ST_OFF;
         d.lh = 1'b0;
         d.nres.oe = 1'b0;
         d.wake_sleep = 1'b0;
         d.wake_silent = 1'b0;
      end else if (op_mode == wd_pkg::MODE_SLEEP) begin
         d.st = wd_pkg::ST_OFF;
         d.lh = 1'b0;
         d.nres.oe = 1'b0;
         d.wake_sleep = 1'b1;
         d.wake_silent = 1'b0;
      end else if (op_mode == wd_pkg::MODE_SILENT) begin
         // Limp home keeps its level while stopped
         d.st = wd_pkg::ST_OFF;
         d.nres.oe = 1'b0;
         d.wake_silent = ~q.wake_sleep;
      end else begin
         case (q.st)
            wd_pkg::ST_OFF: begin
               d.wake_sleep = 1'b0;
               d.wake_silent = 1'b0;
               d.tcnt = '0;
               d.rcnt = '0;
               if (q.wake_sleep) begin
                  // Sleep wake acts like power-up
                  d.st = wd_pkg::ST_RESET;
                  d.nres.oe = 1'b1;
                  d.lh = 1'b0;
                  d.good = '0;
               end else if (q.wake_silent) begin
                  d.st = wd_pkg::ST_WAIT_TXD;
               end else begin
                  d.st = wd_pkg::ST_LEAD;
               end
            end
            wd_pkg::ST_RESET: begin
               if (q.rcnt == wd_pkg::NRES_CNT_W'(RESET_END)) begin
                  d.st = wd_pkg::ST_RELEASE;
                  d.nres.oe = 1'b0;
               end else begin
                  d.rcnt = q.rcnt + 20'h00001;
               end
            end
            wd_pkg::ST_RELEASE: begin
               // Lead time counts from the pin's own rising edge
               if (q.nres_s2) begin
                  d.st = wd_pkg::ST_LEAD;
                  d.tcnt = '0;
               end
            end
            wd_pkg::ST_WAIT_TXD: begin
               if (txd_fall) begin
                  d.st = wd_pkg::ST_LEAD;
                  d.tcnt = '0;
               end
            end
            wd_pkg::ST_LEAD: begin
               if (trig_evt) begin
                  d.st = wd_pkg::ST_CLOSED;
                  d.tcnt = '0;
                  d.good = (good_next == 2'(wd_pkg::GOOD_TRIGGERS)) ? 2'h0 : good_next;
                  d.lh = q.lh && good_next != 2'(wd_pkg::GOOD_TRIGGERS);
               end else if (tick && q.tcnt == wd_pkg::TICK_CNT_W'(LEAD_END)) begin
                  d.st = wd_pkg::ST_RESET;
                  d.nres.oe = 1'b1;
                  d.lh = 1'b1;
                  d.good = '0;
                  d.rcnt = '0;
               end else if (tick) begin
                  d.tcnt = q.tcnt + 12'h001;
               end
            end
            wd_pkg::ST_CLOSED: begin
               if (trig_evt) begin
                  // Premature trigger ends the good run too
                  d.st = wd_pkg::ST_RESET;
                  d.nres.oe = 1'b1;
                  d.lh = 1'b1;
                  d.good = '0;
                  d.rcnt = '0;
               end else if (tick && q.tcnt == wd_pkg::TICK_CNT_W'(CLOSED_END)) begin
                  d.st = wd_pkg::ST_OPEN;
                  d.tcnt = '0;
               end else if (tick) begin
                  d.tcnt = q.tcnt + 12'h001;
               end
            end
            wd_pkg::ST_OPEN: begin
               if (trig_evt) begin
                  d.st = wd_pkg::ST_CLOSED;
                  d.tcnt = '0;
                  d.good = (good_next == 2'(wd_pkg::GOOD_TRIGGERS)) ? 2'h0 : good_next;
                  d.lh = q.lh && good_next != 2'(wd_pkg::GOOD_TRIGGERS);
               end else if (tick && q.tcnt == wd_pkg::TICK_CNT_W'(OPEN_END)) begin
                  d.st = wd_pkg::ST_RESET;
                  d.nres.oe = 1'b1;
                  d.lh = 1'b1;
                  d.good = '0;
                  d.rcnt = '0;
               end else if (tick) begin
                  d.tcnt = q.tcnt + 12'h001;
               end
            end
            default: begin
               d.st = wd_pkg::ST_OFF;
            end
         endcase
      end
   end

   // Power-up enters the reset pulse with limp home off
   always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         q <= '0;
         q.st <= wd_pkg::ST_RESET;
         q.nres.oe <= 1'b1;
         q.trig_s1 <= 1'b1;
         q.trig_s2 <= 1'b1;
         q.txd_s1 <= 1'b1;
         q.txd_s2 <= 1'b1;
         q.txd_prev <= 1'b1;
      end else begin
         q <= d;
      end
   end

   assign nres_pin = q.nres;
   assign limp_home_out = q.lh;

   // Checking helpers
   logic [wd_pkg::NRES_CNT_W-1:0] oe_run_q;
   logic [7:0] low_run_q;

   always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         oe_run_q <= '0;
         low_run_q <= '0;
      end else begin
         oe_run_q <= q.nres.oe ? oe_run_q + 20'h00001 : 20'h00000;
         low_run_q <= (q.trig_s2 || low_run_q == 8'hff) ? 8'h00 : low_run_q + 8'h01;
      end
   end

   default clocking cb @(posedge clk_sys); endclocking
   default disable iff (!rst_n);

   // Event fires on the sample after the low time, with TRIGMIN_CYCLES low samples before it, not counting the current one
   a_trig_low_time: assert property (trig_evt
      |-> !q.trig_s2 && low_run_q == 8'(wd_pkg::TRIGMIN_CYCLES))
      else $error("trigger accepted before the low time elapsed");
   a_pulse_length: assert property ($fell(q.nres.oe) && $past(wd_run)
      |-> oe_run_q == wd_pkg::NRES_CNT_W'(RESET_CYCLES))
      else $error("reset pulse has the wrong length");
   a_lead_expiry: assert property (q.st == wd_pkg::ST_LEAD && wd_run
      && tick && !trig_evt && q.tcnt == wd_pkg::TICK_CNT_W'(LEAD_END)
      |=> q.nres.oe && q.lh)
      else $error("lead expiry did not reset");
   a_lead_closed: assert property (q.st == wd_pkg::ST_LEAD && trig_evt && wd_run
      |=> q.st == wd_pkg::ST_CLOSED && q.tcnt == '0 && !q.nres.oe)
      else $error("lead trigger did not open the closed window");
   a_closed_open: assert property (q.st == wd_pkg::ST_CLOSED && wd_run
      && tick && !trig_evt && q.tcnt == wd_pkg::TICK_CNT_W'(CLOSED_END)
      |=> q.st == wd_pkg::ST_OPEN && q.tcnt == '0)
      else $error("closed window length wrong");
   a_premature_fail: assert property (q.st == wd_pkg::ST_CLOSED && trig_evt && wd_run
      |=> q.st == wd_pkg::ST_RESET && q.lh && q.nres.oe)
      else $error("premature trigger not punished");
   a_open_expiry: assert property (q.st == wd_pkg::ST_OPEN && wd_run
      && tick && !trig_evt && q.tcnt == wd_pkg::TICK_CNT_W'(OPEN_END)
      |=> q.lh && q.nres.oe ##1 q.nres.oe)
      else $error("open window expiry not punished");
   a_open_count: assert property (q.st == wd_pkg::ST_OPEN && wd_run && tick && !trig_evt
      && q.tcnt != wd_pkg::TICK_CNT_W'(OPEN_END)
      |=> q.st == wd_pkg::ST_OPEN && q.tcnt == $past(q.tcnt) + 12'h001)
      else $error("open window does not count oscillator periods");
   a_open_restart: assert property (q.st == wd_pkg::ST_OPEN && trig_evt && wd_run
      |=> q.st == wd_pkg::ST_CLOSED && !q.nres.oe)
      else $error("open trigger did not restart");
   a_lh_release: assert property ($fell(q.lh) && !$past(q.dis_s2)
      && $past(op_mode) != wd_pkg::MODE_SLEEP |-> $past(trig_evt) && q.good == 2'h0)
      else $error("limp home released without good triggers");
   a_lh_disabled: assert property (q.dis_s2 |=> !q.lh ##1 !q.lh)
      else $error("limp home on while disabled");
   a_lh_silent: assert property (op_mode == wd_pkg::MODE_SILENT && !q.dis_s2
      |=> q.lh == $past(q.lh))
      else $error("limp home changed in silent mode");

   // Mode, wake and limp-home bookkeeping
   a_disable_off: assert property (q.dis_s2
      |=> q.st == wd_pkg::ST_OFF && !q.nres.oe)
      else $error("disable did not stop the watchdog");
   a_sleep_off: assert property (op_mode == wd_pkg::MODE_SLEEP
      |=> q.st == wd_pkg::ST_OFF && !q.lh && !q.nres.oe)
      else $error("watchdog active in sleep mode");
   a_silent_stop: assert property (op_mode == wd_pkg::MODE_SILENT
      |=> q.st == wd_pkg::ST_OFF && !q.nres.oe)
      else $error("watchdog active in silent mode");
   a_txd_wait: assert property (q.st == wd_pkg::ST_WAIT_TXD && !txd_fall && wd_run
      |=> q.st == wd_pkg::ST_WAIT_TXD)
      else $error("lead started without a transmit fall");
   a_release_wait: assert property (q.st == wd_pkg::ST_RELEASE && !q.nres_s2 && wd_run
      |=> q.st == wd_pkg::ST_RELEASE && !q.nres.oe)
      else $error("lead started before the reset pin rose");
   a_sleep_wake: assert property (q.st == wd_pkg::ST_OFF && q.wake_sleep && wd_run
      |=> q.st == wd_pkg::ST_RESET && q.nres.oe && !q.lh)
      else $error("sleep wake did not restart like power-up");
   a_lh_with_reset: assert property ($rose(q.lh) |-> $rose(q.nres.oe))
      else $error("limp home rose without a watchdog reset");
   a_good_count: assert property (q.st == wd_pkg::ST_OPEN && trig_evt && wd_run
      && q.lh && q.good != 2'h2 |=> q.lh)
      else $error("limp home released before three triggers");

   c_premature: cover property (q.st == wd_pkg::ST_CLOSED && trig_evt);
   c_open_trig: cover property (q.st == wd_pkg::ST_OPEN && trig_evt);
   c_lh_off: cover property ($fell(q.lh));
   c_silent_wake: cover property (q.st == wd_pkg::ST_WAIT_TXD ##1 q.st == wd_pkg::ST_LEAD);
   c_sleep_wake: cover property (q.st == wd_pkg::ST_OFF && q.wake_sleep && wd_run);
endmodule

// ---- hw/wd_pkg.sv ----
// Shared constants and types of the window watchdog
package wd_pkg;
   // Time base
   localparam int CLK_PERIOD_NS = 4;
   // Reset pulse length, also used after power-up
   localparam int T_NRES_MS = 4;
   localparam int NRES_CYCLES = T_NRES_MS * 1000000 / CLK_PERIOD_NS;
   localparam int NRES_CNT_W = 20;
   // Least low time of a valid trigger, rounded up
   localparam int T_TRIGMIN_NS = 200;
   localparam int TRIGMIN_CYCLES = (T_TRIGMIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int LOW_CNT_W = 6;
   // Window lengths in oscillator periods
   localparam int LEAD_TICKS = 3984;
   localparam int CLOSED_TICKS = 527;
   localparam int OPEN_TICKS = 553;
   localparam int TICK_CNT_W = 12;
   // Correct triggers that switch limp home off again
   localparam int GOOD_TRIGGERS = 3;
   // Fallback oscillator period, nominal 51 kOhm figure
   localparam int T_OSC_FALLBACK_NS = 39300;
   localparam int OSC_FALLBACK_CYCLES = T_OSC_FALLBACK_NS / CLK_PERIOD_NS;
   localparam int OSC_CNT_W = 16;

   typedef enum logic [1:0] {
      MODE_NORMAL = 2'h0,
      MODE_FAILSAFE = 2'h1,
      MODE_SILENT = 2'h2,
      MODE_SLEEP = 2'h3
   } op_mode_t;

   typedef enum logic [6:0] {
      ST_OFF = 7'h01,
      ST_RESET = 7'h02,
      ST_RELEASE = 7'h04,
      ST_WAIT_TXD = 7'h08,
      ST_LEAD = 7'h10,
      ST_CLOSED = 7'h20,
      ST_OPEN = 7'h40
   } wd_state_t;

   // Open-drain pin drive: oe high pulls the pin to o
   typedef struct packed {
      logic o;
      logic oe;
   } od_pin_t;

   typedef struct packed {
      logic trig_s1;
      logic trig_s2;
      logic txd_s1;
      logic txd_s2;
      logic dis_s1;
      logic dis_s2;
      logic nres_s1;
      logic nres_s2;
      logic txd_prev;
      logic armed;
      logic [LOW_CNT_W-1:0] low_cnt;
      wd_state_t st;
      logic [TICK_CNT_W-1:0] tcnt;
      logic [NRES_CNT_W-1:0] rcnt;
      logic [1:0] good;
      logic wake_sleep;
      logic wake_silent;
      logic lh;
      od_pin_t nres;
   } wd_regs_t;

   typedef struct packed {
      logic f_s1;
      logic f_s2;
      logic [OSC_CNT_W-1:0] cnt;
      logic tick;
   } osc_regs_t;
endpackage

// ---- hw/osc_timebase.sv ----
// Watchdog oscillator: one-cycle tick per oscillator period
`timescale 1ns/1ps
module osc_timebase #(
   parameter int FALLBACK = wd_pkg::OSC_FALLBACK_CYCLES
) (
   input wire logic clk_sys,
   input wire logic rst_n,
   input wire logic [wd_pkg::OSC_CNT_W-1:0] osc_period_cfg,
   input wire logic osc_resistor_fault,
   output logic tick
);
   wd_pkg::osc_regs_t q;
   wd_pkg::osc_regs_t d;
   logic [wd_pkg::OSC_CNT_W-1:0] period;

   always_comb begin
      d = q;
      d.f_s1 = osc_resistor_fault;
      d.f_s2 = q.f_s1;
      // Shorted or open resistor pin runs from the fallback period
      if (q.f_s2 || osc_period_cfg == '0) begin
         period = wd_pkg::OSC_CNT_W'(FALLBACK);
      end else begin
         period = osc_period_cfg;
      end
      d.tick = 1'b0;
      if (q.cnt >= period - 16'h0001) begin
         d.cnt = '0;
         d.tick = 1'b1;
      end else begin
         d.cnt = q.cnt + 16'h0001;
      end
   end

   always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         q <= '0;
      end else begin
         q <= d;
      end
   end

   assign tick = q.tick;
endmodule

// ---- bench/host_model.sv ----
// Host microcontroller model: trigger pulses and reset pin pull-up
`timescale 1ns/1ps
module host_model (
   input wire logic clk_sys,
   input wire wd_pkg::od_pin_t nres_pin,
   output logic wd_trigger_in_n,
   output logic nres_in
);
   // Pull-up on the reset pin, so a released pin reads high
   assign nres_in = nres_pin.oe ? nres_pin.o : 1'h1;
   initial wd_trigger_in_n = 1'h1;
   // Caller picks the moment: lead time, mid open window or early
   task automatic pulse(input int low_cycles);
      @(posedge clk_sys);
      wd_trigger_in_n <= 1'h0;
      repeat (low_cycles) @(posedge clk_sys);
      wd_trigger_in_n <= 1'h1;
   endtask
endmodule

// ---- bench/tb_top.sv ----
// Self-checking bench of the window watchdog
`timescale 1ns/1ps
`define CHK(got, exp, msg) begin comparisons++; if ((got) !== (exp)) begin bad_count++; \
   $display("[FAIL] %0t %s", $time, msg); end end
module tb_top;
   localparam int RST_C = 20;
   localparam int PER = 4;
   localparam int FB = 8;
   localparam int LEAD = wd_pkg::LEAD_TICKS * PER;
   localparam int WIN = (wd_pkg::CLOSED_TICKS + wd_pkg::OPEN_TICKS) * FB;
   typedef struct {int wait_c; int low_c; logic oe; logic lh;} row_t;
   logic clk_sys;
   logic rst_n;
   logic wd_trigger_in_n;
   logic wd_disable_in;
   logic txd_in;
   logic nres_in;
   wd_pkg::op_mode_t op_mode;
   logic [wd_pkg::OSC_CNT_W-1:0] osc_period_cfg;
   logic osc_resistor_fault;
   wd_pkg::od_pin_t nres_pin;
   logic limp_home_out;
   int bad_count;
   int comparisons;
   int n;
   row_t rows[5];

   window_watchdog_limp_home #(.RESET_CYCLES(RST_C), .OSC_FALLBACK(FB)) i_dut (
      .clk_sys(clk_sys),
      .rst_n(rst_n),
      .wd_trigger_in_n(wd_trigger_in_n),
      .wd_disable_in(wd_disable_in),
      .txd_in(txd_in),
      .nres_in(nres_in),
      .op_mode(op_mode),
      .osc_period_cfg(osc_period_cfg),
      .osc_resistor_fault(osc_resistor_fault),
      .nres_pin(nres_pin),
      .limp_home_out(limp_home_out)
   );

   host_model i_host (
      .clk_sys(clk_sys),
      .nres_pin(nres_pin),
      .wd_trigger_in_n(wd_trigger_in_n),
      .nres_in(nres_in)
   );

   task automatic tally_and_finish();
      $display("compares %0d mismatches %0d", comparisons, bad_count);
      if (bad_count == 0 && comparisons > 0) begin
         $display("NO MISMATCHES");
      end else begin
         $display("MISMATCHES SEEN");
      end
      $finish;
   endtask

   // Sample 1 ns after the edge so the edge's updates have landed
   task automatic cyc(input int c);
      repeat (c) @(posedge clk_sys);
      #1;
   endtask

   task automatic wait_oe(input logic v, input int lim, output int cnt);
      cnt = 0;
      while (nres_pin.oe !== v) begin
         cyc(1);
         cnt++;
         if (cnt > lim) begin
            bad_count++;
            $display("[FAIL] %0t wait on reset output ran out", $time);
            tally_and_finish();
         end
      end
   endtask

   // Counts cycles in which the reset pin is pulled low
   task automatic watch_idle(input int lim, output int hi);
      hi = 0;
      repeat (lim) begin
         cyc(1);
         if (nres_pin.oe !== 1'h0) hi++;
      end
   endtask

   initial begin
      clk_sys = 1'h0;
      forever #2 clk_sys = ~clk_sys;
   end

   initial begin
      bad_count = 0;
      comparisons = 0;
      rst_n = 1'h0;
      wd_disable_in = 1'h0;
      txd_in = 1'h1;
      op_mode = wd_pkg::MODE_NORMAL;
      osc_period_cfg = 16'h0004;
      osc_resistor_fault = 1'h0;
      // Lead trigger, 50-cycle glitch, two open-window triggers, early one
      rows[0] = '{100, 60, 1'h0, 1'h1};
      rows[1] = '{30, 50, 1'h0, 1'h1};
      rows[2] = '{3000, 60, 1'h0, 1'h1};
      rows[3] = '{3100, 52, 1'h0, 1'h0};
      rows[4] = '{100, 60, 1'h1, 1'h1};
      cyc(10);
      `CHK(nres_pin.oe, 1'h1, "reset not held")
      `CHK(limp_home_out, 1'h0, "limp home on at power-up")
      `CHK(nres_pin.o, 1'h0, "reset pin not pulled low")
      @(posedge clk_sys);
      rst_n <= 1'h1;
      wait_oe(1'h0, 100, n);
      `CHK(n >= RST_C - 1 && n <= RST_C + 4, 1'h1, "reset pulse length")
      $display("test power-up done");
      wait_oe(1'h1, LEAD + 100, n);
      `CHK(n >= LEAD - 4 && n <= LEAD + 12, 1'h1, "lead time length")
      `CHK(limp_home_out, 1'h1, "limp home after lead expiry")
      $display("test lead expiry done");
      wait_oe(1'h0, 100, n);
      foreach (rows[i]) begin
         cyc(rows[i].wait_c);
         i_host.pulse(rows[i].low_c);
         cyc(4);
         `CHK(nres_pin.oe, rows[i].oe, "row reset output")
         `CHK(limp_home_out, rows[i].lh, "row limp home")
      end
      $display("test trigger table done");
      // Fallback period doubles the window length
      osc_resistor_fault <= 1'h1;
      wait_oe(1'h0, 100, n);
      cyc(200);
      i_host.pulse(60);
      wait_oe(1'h1, WIN + 100, n);
      `CHK(n >= WIN - 20 && n <= WIN + 8, 1'h1, "open window expiry time")
      `CHK(limp_home_out, 1'h1, "limp home after open expiry")
      osc_resistor_fault <= 1'h0;
      $display("test fallback done");
      wait_oe(1'h0, 100, n);
      cyc(100);
      i_host.pulse(60);
      op_mode <= wd_pkg::MODE_SILENT;
      watch_idle(5000, n);
      `CHK(n, 0, "reset while silent")
      `CHK(limp_home_out, 1'h1, "limp home lost in silent")
      // Lead must wait for the transmit fall, not the mode change
      op_mode <= wd_pkg::MODE_FAILSAFE;
      cyc(1000);
      txd_in <= 1'h0;
      wait_oe(1'h1, LEAD + 100, n);
      `CHK(n >= LEAD - 4 && n <= LEAD + 12, 1'h1, "lead after silent wake")
      txd_in <= 1'h1;
      $display("test silent done");
      wd_disable_in <= 1'h1;
      cyc(5);
      `CHK(nres_pin.oe, 1'h0, "pulse not aborted by disable")
      `CHK(limp_home_out, 1'h0, "limp home on while disabled")
      watch_idle(5000, n);
      `CHK(n, 0, "reset while disabled")
      wd_disable_in <= 1'h0;
      cyc(100);
      i_host.pulse(60);
      cyc(100);
      i_host.pulse(60);
      cyc(4);
      `CHK(nres_pin.oe, 1'h1, "early trigger missed")
      `CHK(limp_home_out, 1'h1, "limp home after early trigger")
      $display("test disable done");
      op_mode <= wd_pkg::MODE_SLEEP;
      cyc(5);
      `CHK(limp_home_out, 1'h0, "limp home on in sleep")
      `CHK(nres_pin.oe, 1'h0, "reset held in sleep")
      op_mode <= wd_pkg::MODE_NORMAL;
      cyc(5);
      `CHK(nres_pin.oe, 1'h1, "no reset on sleep wake")
      `CHK(limp_home_out, 1'h0, "limp home on after sleep wake")
      $display("test sleep done");
      tally_and_finish();
   end
endmodule
